// ==== verilog/audio_modulated_pwm_pair.sv ====
// Two audio-modulated PWM generators with AHB-Lite register access
`timescale 1ns/1ps
`default_nettype none
`include "pwm_pair_cfg.svh"

// Behaviour
// - two generators, audio or fixed duty
// - four selectable paths with volume each
// - outputs routable to general-purpose pins
// - outputs never feed back as sources
// - mixer fields at indices 0x640-0x64F
// - cycle time equals the sample period
// - each generator runs only when enabled
// - override clear: duty follows mixer
// - override set: duty from override level
// - clock select codes 000/001/010, rest reserved
// - ten-bit level, 0x000 half, 0x200 zero
// - underclocked path enable fails, others unaffected
module audio_modulated_pwm_pair (
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic ce,
	// AHB-Lite slave
	input wire pwm_pair_pkg::ahb_req_t ahb,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Audio from core routing
	input wire pwm_pair_pkg::audio_in_t audio,
	// General-purpose pins
	input wire logic [1:0] gpio_pwm_function,
	output logic [1:0] gpio_pwm_out
);
	import pwm_pair_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Registers
	logic [1:0] enable_q;
	logic [1:0] duty_override_q;
	logic [2:0] clk_sel_q;
	logic [4:0] rate_q;
	logic [1:0][9:0] override_duty_level_q;
	logic [1:0][3:0][7:0] mixer_source_select_q;
	logic [1:0][3:0][7:0] mixer_volume_q;
	logic path_rejected_q;
	logic wr_pend_q;
	logic [11:0] wr_idx_q;
	logic [31:0] hrdata_q;

	// Active path count, used for the core clock budget
	function automatic logic [3:0] count_paths(input logic [1:0][3:0][7:0] src);
		logic [3:0] n;
		n = 4'h0;
		for (int g = 0; g < 2; g++)
			for (int p = 0; p < 4; p++)
				if (src[g][p] != 8'h00)
					n = n + 4'h1;
		return n;
	endfunction

	// Divider for the PWM clock tick, zero for reserved codes
	function automatic logic [2:0] tick_div(input logic [2:0] sel);
		unique case (sel)
			`CLK_SEL_LOW: return 3'h4;
			`CLK_SEL_MID: return 3'h2;
			`CLK_SEL_HIGH: return 3'h1;
			default: return 3'h0;
		endcase
	endfunction

	wire addr_ok = ahb.hsel && ahb.htrans[1] && ahb.hready;
	wire [11:0] addr_idx = ahb.haddr[13:2];
	wire in_mix = (wr_idx_q >= `IDX_MIX_FIRST) && (wr_idx_q <= `IDX_MIX_LAST);
	wire mix_gen = wr_idx_q[3];
	wire [1:0] mix_path = wr_idx_q[2:1];
	wire [3:0] paths_now = count_paths(mixer_source_select_q);
	wire path_adds = in_mix && !wr_idx_q[0] && ahb.hwdata[7:0] != 8'h00
		&& mixer_source_select_q[mix_gen][mix_path] == 8'h00;
	wire path_fail = wr_pend_q && path_adds && paths_now >= `MAX_ACTIVE_PATHS;

	// Address phase capture, zero wait state
	always_ff @(posedge clk_sys or negedge nrst)
		if (!nrst)
		begin
			wr_pend_q <= 1'b0;
			wr_idx_q <= 12'h000;
		end
		else if (ce)
		begin
			wr_pend_q <= addr_ok && ahb.hwrite;
			wr_idx_q <= addr_idx;
		end

	// Control writes
	always_ff @(posedge clk_sys or negedge nrst)
		if (!nrst)
		begin
			enable_q <= 2'h0;
			duty_override_q <= 2'h0;
			clk_sel_q <= `CLK_SEL_LOW;
			rate_q <= 5'h00;
			override_duty_level_q <= {2{`RST_LEVEL}};
		end
		else if (ce && wr_pend_q)
		begin
			if (wr_idx_q == `IDX_DRIVE_CTRL)
			begin
				enable_q <= {ahb.hwdata[`BIT_ENA_TWO], ahb.hwdata[`BIT_ENA_ONE]};
				duty_override_q <= {ahb.hwdata[`BIT_OVD_TWO], ahb.hwdata[`BIT_OVD_ONE]};
				clk_sel_q <= ahb.hwdata[`POS_CLK_SEL +: 3];
			end
			if (wr_idx_q == `IDX_LEVEL_ONE)
				override_duty_level_q[0] <= ahb.hwdata[9:0];
			if (wr_idx_q == `IDX_LEVEL_TWO)
				override_duty_level_q[1] <= ahb.hwdata[9:0];
			if (wr_idx_q == `IDX_RATE)
				rate_q <= ahb.hwdata[4:0];
		end

	// Mixer fields; a path that exceeds the clock budget is refused
	always_ff @(posedge clk_sys or negedge nrst)
		if (!nrst)
		begin
			mixer_source_select_q <= '0;
			mixer_volume_q <= {8{`RST_VOLUME}};
		end
		else if (ce && wr_pend_q && in_mix)
		begin
			if (wr_idx_q[0])
				mixer_volume_q[mix_gen][mix_path] <= ahb.hwdata[7:0];
			else if (!path_fail)
				mixer_source_select_q[mix_gen][mix_path] <= ahb.hwdata[7:0];
		end

	// Refused-path flag, write 1 clears, a new refusal wins
	always_ff @(posedge clk_sys or negedge nrst)
		if (!nrst)
			path_rejected_q <= 1'b0;
		else if (ce)
		begin
			if (path_fail)
				path_rejected_q <= 1'b1;
			else if (wr_pend_q && wr_idx_q == `IDX_PATH_STATUS && ahb.hwdata[0])
				path_rejected_q <= 1'b0;
		end

	// Read data prepared in the address phase
	always_ff @(posedge clk_sys or negedge nrst)
		if (!nrst)
			hrdata_q <= 32'h0000_0000;
		else if (ce && addr_ok && !ahb.hwrite)
		begin
			hrdata_q <= 32'h0000_0000;
			if (addr_idx == `IDX_DRIVE_CTRL)
				hrdata_q <= {21'h0, clk_sel_q, 2'h0, duty_override_q, 2'h0, enable_q};
			else if (addr_idx == `IDX_LEVEL_ONE)
				hrdata_q <= {22'h0, override_duty_level_q[0]};
			else if (addr_idx == `IDX_LEVEL_TWO)
				hrdata_q <= {22'h0, override_duty_level_q[1]};
			else if (addr_idx == `IDX_RATE)
				hrdata_q <= {27'h0, rate_q};
			else if (addr_idx == `IDX_PATH_STATUS)
				hrdata_q <= {24'h0, paths_now, 3'h0, path_rejected_q};
			else if (addr_idx >= `IDX_MIX_FIRST && addr_idx <= `IDX_MIX_LAST)
				hrdata_q <= {24'h0, addr_idx[0] ? mixer_volume_q[addr_idx[3]][addr_idx[2:1]]
					: mixer_source_select_q[addr_idx[3]][addr_idx[2:1]]};
		end

	always_ff @(posedge clk_sys or negedge nrst)
		if (!nrst)
		begin
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	assign hrdata = hrdata_q;

	////////////////////////////////////////////////////////////////////////////////
	// Mixers: source 0 is silence, 1-8 pick a routed sample, volume 0x80 is unity
	function automatic logic [9:0] mix(input logic [3:0][7:0] src, input logic [3:0][7:0] vol,
		input logic [7:0][15:0] smp);
		logic signed [25:0] acc;
		logic signed [15:0] s;
		acc = 26'sh0;
		for (int p = 0; p < 4; p++)
		begin
			s = (src[p] >= 8'h01 && src[p] <= 8'h08) ? smp[3'(src[p] - 8'h01)] : 16'sh0;
			acc = acc + 26'(s * $signed({1'b0, vol[p]}));
		end
		acc = acc >>> 7;
		if (acc > 26'sh7fff)
			acc = 26'sh7fff;
		else if (acc < -26'sh8000)
			acc = -26'sh8000;
		return acc[15:6];
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Generators
	logic [2:0] div_cnt_q;
	wire [2:0] div = tick_div(clk_sel_q);
	wire pwm_tick = div != 3'h0 && div_cnt_q == div - 3'h1;

	always_ff @(posedge clk_sys or negedge nrst)
		if (!nrst)
			div_cnt_q <= 3'h0;
		else if (ce)
			div_cnt_q <= pwm_tick || div == 3'h0 ? 3'h0 : div_cnt_q + 3'h1;

	logic [1:0][11:0] cnt_q;
	logic [1:0][11:0] thresh_q;
	logic [1:0] pwm_q;

	for (genvar g = 0; g < 2; g++)
	begin : gen
		wire [9:0] level = duty_override_q[g] ? override_duty_level_q[g]
			: mix(mixer_source_select_q[g], mixer_volume_q[g], audio.sample);
		wire [9:0] offset = level ^ 10'h200;

		always_ff @(posedge clk_sys or negedge nrst)
			if (!nrst)
			begin
				cnt_q[g] <= 12'h000;
				thresh_q[g] <= 12'h000;
			end
			else if (ce)
			begin
				if (!enable_q[g])
					cnt_q[g] <= 12'h000;
				else if (audio.tick)
				begin
					cnt_q[g] <= 12'h000;
					thresh_q[g] <= 12'({2'h0, offset} << clk_sel_q[1:0]) >> 2;
				end
				else if (pwm_tick && cnt_q[g] != 12'hfff)
					cnt_q[g] <= cnt_q[g] + 12'h001;
			end

		always_ff @(posedge clk_sys or negedge nrst)
			if (!nrst)
				pwm_q[g] <= 1'b0;
			else if (ce)
				pwm_q[g] <= enable_q[g] && !audio.tick && cnt_q[g] < thresh_q[g];

		always_ff @(posedge clk_sys or negedge nrst)
			if (!nrst)
				gpio_pwm_out[g] <= 1'b0;
			else if (ce)
				gpio_pwm_out[g] <= gpio_pwm_function[g] && pwm_q[g];

		dis_low_a: assert property (@(posedge clk_sys) disable iff (!nrst)
			ce && !enable_q[g] |=> !pwm_q[g])
			else $error("disabled generator drives high");
		cnt_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
			ce && !enable_q[g] |=> cnt_q[g] == 12'h000)
			else $error("disabled counter not reset");
		cycle_start_a: assert property (@(posedge clk_sys) disable iff (!nrst)
			ce && enable_q[g] && audio.tick |=> cnt_q[g] == 12'h000)
			else $error("cycle did not restart on sample");
		duty_latch_a: assert property (@(posedge clk_sys) disable iff (!nrst)
			ce && !audio.tick |=> $stable(thresh_q[g]))
			else $error("duty changed mid cycle");
		gpio_route_a: assert property (@(posedge clk_sys) disable iff (!nrst)
			ce && !gpio_pwm_function[g] |=> !gpio_pwm_out[g])
			else $error("pin driven while not routed");
		zero_duty_a: assert property (@(posedge clk_sys) disable iff (!nrst)
			ce && audio.tick && enable_q[g] && duty_override_q[g] && override_duty_level_q[g] == 10'h200
			|=> thresh_q[g] == 12'h000)
			else $error("level 0x200 not zero duty");
		ovd_level_a: assert property (@(posedge clk_sys) disable iff (!nrst)
			ce && audio.tick && enable_q[g] && clk_sel_q == `CLK_SEL_HIGH && duty_override_q[g]
			|=> thresh_q[g] == {2'h0, $past(override_duty_level_q[g]) ^ 10'h200})
			else $error("override level not used");
	end

	reject_keep_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		path_fail && ce |=> path_rejected_q && $stable(mixer_source_select_q))
		else $error("refused path changed sources");
	budget_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		paths_now <= `MAX_ACTIVE_PATHS)
		else $error("active paths exceed budget");
endmodule
`default_nettype wire

// ==== verilog/pwm_pair_cfg.svh ====
// Register offsets, field positions, reset values and timing counts of the PWM pair
`ifndef PWM_PAIR_CFG_SVH
`define PWM_PAIR_CFG_SVH
`define IDX_DRIVE_CTRL 12'h030
`define IDX_LEVEL_ONE 12'h031
`define IDX_LEVEL_TWO 12'h032
`define IDX_RATE 12'h033
`define IDX_PATH_STATUS 12'h034
`define IDX_MIX_FIRST 12'h640
`define IDX_MIX_LAST 12'h64f
`define BIT_ENA_ONE 0
`define BIT_ENA_TWO 1
`define BIT_OVD_ONE 4
`define BIT_OVD_TWO 5
`define POS_CLK_SEL 8
`define RST_LEVEL 10'h100
`define RST_VOLUME 8'h80
`define RATE_ASYNC_MIN 5'h08
`define MAX_ACTIVE_PATHS 4'h6
`define CLK_SEL_LOW 3'h0
`define CLK_SEL_MID 3'h1
`define CLK_SEL_HIGH 3'h2
`define RATE_CHANGE_WAIT_US 125
`define CLK_SYS_MHZ 125
`define RATE_CHANGE_WAIT_CYC (`RATE_CHANGE_WAIT_US * `CLK_SYS_MHZ)
`endif

// ==== verilog/pwm_pair_pkg.sv ====
// Types shared by the PWM pair and its bench
package pwm_pair_pkg;
	typedef struct packed {
		logic tick;
		logic [7:0][15:0] sample;
	} audio_in_t;
	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
		logic hready;
	} ahb_req_t;
endpackage

// ==== bench/pwm_far_side.sv ====
// Audio source and pin monitor standing beside the PWM pair
`timescale 1ns/1ps
`default_nettype none
module pwm_far_side #(parameter int PERIOD = 1040)
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Audio source
	input wire logic [7:0][15:0] smp_set,
	output pwm_pair_pkg::audio_in_t audio,
	// Pins and measured high time per sample period
	input wire logic [1:0] pin,
	output logic [10:0] hi_one,
	output logic [10:0] hi_two,
	output int frames
);
	int cnt;
	logic [10:0] n1;
	logic [10:0] n2;
	////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			cnt <= 0;
			n1 <= '0;
			n2 <= '0;
			frames <= 0;
			hi_one <= '0;
			hi_two <= '0;
			audio <= '0;
		end
		else
		begin
			// One fixed sample rate for every source
			cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
			audio.tick <= (cnt == PERIOD - 1);
			if (cnt == PERIOD - 1)
				audio.sample <= smp_set;
			if (audio.tick)
			begin
				hi_one <= n1;
				hi_two <= n2;
				n1 <= 11'(pin[0]);
				n2 <= 11'(pin[1]);
				frames <= frames + 1;
			end
			else
			begin
				n1 <= n1 + 11'(pin[0]);
				n2 <= n2 + 11'(pin[1]);
			end
		end
	end
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
// Self-checking bench for the PWM pair
`timescale 1ns/1ps
`default_nettype none
`include "pwm_pair_cfg.svh"
module tb_top;
	import pwm_pair_pkg::*;
	logic clk_sys;
	logic nrst;
	logic m_sel;
	logic m_wr;
	logic [1:0] m_tr;
	logic [31:0] m_a;
	logic [31:0] m_wd;
	logic [31:0] rd;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic [1:0] fn;
	logic [1:0] pin;
	logic [7:0][15:0] smp;
	logic [10:0] hi_one;
	logic [10:0] hi_two;
	logic [9:0] lv;
	int frames;
	int mismatches;
	int cmp_count;
	int seed;
	ahb_req_t ahb;
	audio_in_t audio;
	logic [31:0] model [int];
	logic [11:0] ids [8] = '{12'h030, 12'h031, 12'h032, 12'h033, 12'h641, 12'h64f, 12'h63f, 12'h650};
	logic [9:0] lvs [5] = '{10'h000, 10'h200, 10'h100, 10'h3ff, 10'h1ff};
	assign ahb = {m_sel, m_a, m_tr, m_wr, 3'h2, m_wd, hreadyout};
	audio_modulated_pwm_pair i_audio_modulated_pwm_pair (.clk_sys, .nrst, .ce(1'b1), .ahb, .hrdata,
		.hreadyout, .hresp, .audio, .gpio_pwm_function(fn), .gpio_pwm_out(pin));
	pwm_far_side i_pwm_far_side (.clk_sys, .nrst, .smp_set(smp), .audio, .pin, .hi_one, .hi_two, .frames);
	////////////////////////////////////////////////////////////////
	task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e)
		begin
			mismatches++;
			$display("[FAIL] %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic chk_duty(input string nm, input logic [10:0] e, input logic [10:0] s);
		cmp_count++;
		if (s !== e)
		begin
			mismatches++;
			$display("[FAIL] %s exp %0d seen %0d", nm, e, s);
		end
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic wait_rdy;
		int n;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 64);
		rd = hrdata;
		chk_reg("hresp", 32'h0, {31'h0, hresp});
		if (hreadyout !== 1'b1)
		begin
			mismatches++;
			tally_and_finish();
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] x, input logic [31:0] d);
		m_sel <= 1'b1;
		m_a <= {18'h0, x, 2'h0};
		m_tr <= 2'h2;
		m_wr <= w;
		wait_rdy();
		m_sel <= 1'b0;
		m_tr <= 2'h0;
		m_wd <= d;
		wait_rdy();
	endtask
	function automatic logic [31:0] msk(input logic [11:0] x);
		if (x == `IDX_DRIVE_CTRL)
			return 32'h733;
		if (x == `IDX_LEVEL_ONE || x == `IDX_LEVEL_TWO)
			return 32'h3ff;
		if (x == `IDX_RATE)
			return 32'h1f;
		if (x >= `IDX_MIX_FIRST && x <= `IDX_MIX_LAST)
			return 32'hff;
		return 32'h0;
	endfunction
	task automatic wr(input logic [11:0] x, input logic [31:0] d);
		xfer(1'b1, x, d);
		model[x] = d & msk(x);
	endtask
	task automatic rdc(input logic [11:0] x);
		xfer(1'b0, x, 32'h0);
		chk_reg($sformatf("reg %h", x), model.exists(x) ? model[x] : 32'h0, rd);
	endtask
	// Waits three sample periods so a whole fresh period is measured
	task automatic duty(input logic [10:0] e1, input logic [10:0] e2);
		int f;
		f = frames + 3;
		for (int k = 0; k < 4000 && frames < f; k++)
			@(posedge clk_sys);
		if (frames < f)
		begin
			mismatches++;
			tally_and_finish();
		end
		chk_duty("gen one high", e1, hi_one);
		chk_duty("gen two high", e2, hi_two);
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		clk_sys = 1'b0;
		forever
			#4 clk_sys = ~clk_sys;
	end
	initial
	begin
		repeat (90000) @(posedge clk_sys);
		mismatches++;
		tally_and_finish();
	end
	initial
	begin
		seed = 32'hc5672354;
		{nrst, m_sel, m_wr, m_tr, m_a, m_wd, fn, smp} = '0;
		model[`IDX_LEVEL_ONE] = 32'h100;
		model[`IDX_LEVEL_TWO] = 32'h100;
		for (int i = 1; i < 16; i += 2)
			model[`IDX_MIX_FIRST + i] = 32'h80;
		repeat (4) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		foreach (ids[i])
			rdc(ids[i]);
		foreach (ids[i])
		begin
			wr(ids[i], $random(seed));
			rdc(ids[i]);
		end
		$display("test registers done");
		fn <= 2'h3;
		wr(`IDX_DRIVE_CTRL, 32'h233);
		for (int i = 0; i < 6; i++)
		begin
			lv = (i < 5) ? lvs[i] : 10'($random(seed));
			wr(`IDX_LEVEL_ONE, {22'h0, lv});
			wr(`IDX_LEVEL_TWO, {22'h0, ~lv});
			duty({1'b0, lv ^ 10'h200}, {1'b0, ~lv ^ 10'h200});
		end
		wr(`IDX_DRIVE_CTRL, 32'h231);
		duty({1'b0, lv ^ 10'h200}, 11'h0);
		$display("test override done");
		smp <= {$random(seed), $random(seed), $random(seed), $random(seed)};
		wr(12'h641, 32'h80);
		wr(`IDX_DRIVE_CTRL, 32'h203);
		wr(12'h640, 32'h1);
		wr(12'h648, 32'h8);
		duty({1'b0, smp[0][15:6] ^ 10'h200}, {1'b0, smp[7][15:6] ^ 10'h200});
		$display("test mixer done");
		for (int p = 1; p < 4; p++)
			wr(12'h640 + 12'(2 * p), 32'h2);
		wr(12'h64a, 32'h3);
		xfer(1'b1, 12'h64c, 32'h4);
		rdc(12'h64c);
		rdc(12'h640);
		xfer(1'b0, `IDX_PATH_STATUS, 32'h0);
		chk_reg("status", 32'h61, rd);
		xfer(1'b1, `IDX_PATH_STATUS, 32'h1);
		xfer(1'b0, `IDX_PATH_STATUS, 32'h0);
		chk_reg("status", 32'h60, rd);
		$display("test path budget done");
		for (int p = 0; p < 16; p += 2)
			wr(12'h640 + 12'(p), 32'h0);
		repeat (`RATE_CHANGE_WAIT_CYC) @(posedge clk_sys);
		wr(`IDX_RATE, 32'h3);
		rdc(`IDX_RATE);
		$display("test rate change done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
